// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the dual pwm block: ahb-lite register tasks,
 * waveform measurement on the shared pins, pin sharing and deep sleep.
 * Assumes dpwm_pkg and dpwm_top are compiled before this file.
 */
`timescale 1ns/10ps
module tb_top;
	import dpwm_pkg::*;

	// clock and reset
	logic        CORE_CLK   = 1'b0;
	logic        RST_N      = 1'b0;
	// ahb-lite
	logic        HSEL       = 1'b0;
	logic [31:0] HADDR      = 32'h0;
	logic [1:0]  HTRANS     = 2'h0;
	logic        HWRITE     = 1'b0;
	logic [2:0]  HSIZE      = 3'h2;
	logic [31:0] HWDATA     = 32'h0;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	// sleep and pins
	logic        DEEP_SLEEP = 1'b0;
	logic [1:0]  GPIO_OUT   = 2'h0;
	logic [1:0]  GPIO_OE    = 2'h0;
	logic [1:0]  PIN_OUT;
	logic [1:0]  PIN_OE;

	int          err_count  = 0;
	int          n_checks   = 0;
	int          cycles     = 0;
	int          old_len[2] = '{0, 0};
	int          hi;
	int          rise;
	logic        lvl;
	logic [31:0] rdat;
	// divide, polarity, period, duty, fraction
	int          tbl[9][5]  = '{'{1, 0, 7, 2, 1}, '{2, 1, 5, 1, 2},
		'{3, 0, 6, 3, 3}, '{0, 0, 0, 5, 0}, '{0, 1, 0, 5, 0},
		'{0, 0, 6, 6, 0}, '{0, 1, 5, 9, 0}, '{0, 0, 255, 128, 0},
		'{0, 0, 10, 3, 0}};

	dpwm_top dut (
		.CORE_CLK  (CORE_CLK),
		.RST_N     (RST_N),
		.HSEL      (HSEL),
		.HADDR     (HADDR),
		.HTRANS    (HTRANS),
		.HWRITE    (HWRITE),
		.HSIZE     (HSIZE),
		.HWDATA    (HWDATA),
		.HREADY    (HREADYOUT),
		.HRDATA    (HRDATA),
		.HREADYOUT (HREADYOUT),
		.HRESP     (HRESP),
		.DEEP_SLEEP(DEEP_SLEEP),
		.GPIO_OUT  (GPIO_OUT),
		.GPIO_OE   (GPIO_OE),
		.PIN_OUT   (PIN_OUT),
		.PIN_OE    (PIN_OE)
	);

	always #50 CORE_CLK = ~CORE_CLK;

	// ********************************************************
	// reporting
	// ********************************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	// hang guard, well above the longest sequence
	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_cnt(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			err_count++;
			$display("Error at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt

	// ********************************************************
	// bus and pin tasks
	// ********************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask : cyc

	// hready is registered, so its negedge value is what the edge samples
	task automatic wait_ready(output logic [31:0] q);
		do begin
			@(negedge CORE_CLK);
		end while (HREADYOUT !== 1'b1);
		q = HRDATA;
		@(posedge CORE_CLK);
	endtask : wait_ready

	task automatic xfer(input logic w, input logic [9:0] idx,
		input logic [3:0] wd, output logic [31:0] q);
		@(posedge CORE_CLK);
		HSEL   <= 1'b1;
		HTRANS <= 2'b10;
		HWRITE <= w;
		HADDR  <= {20'h0, idx, 2'b00};
		wait_ready(q);
		HSEL   <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= {28'h0, wd};
		wait_ready(q);
	endtask : xfer

	task automatic wr(input logic [9:0] idx, input logic [3:0] wd);
		logic [31:0] q;
		xfer(1'b1, idx, wd, q);
	endtask : wr

	task automatic rd(input logic [9:0] idx, output logic [31:0] q);
		xfer(1'b0, idx, 4'h0, q);
	endtask : rd

	// window is a whole number of periods or the level is constant, so its phase does not matter
	task automatic measure(input int ch, input int len,
		output int h, output int r);
		logic prev;
		h = 0;
		r = 0;
		@(negedge CORE_CLK);
		prev = PIN_OUT[ch];
		repeat (len) begin
			@(negedge CORE_CLK);
			if (PIN_OUT[ch] === 1'b1) h++;
			if (PIN_OUT[ch] === 1'b1 && prev === 1'b0) r++;
			prev = PIN_OUT[ch];
		end
	endtask : measure

	task automatic cfg(input int ch, input int dv, input int pol,
		input int per, input int duty, input int fr);
		logic [9:0]  b;
		logic [9:0]  c;
		logic [31:0] q;
		b = ch ? DPWM_IDX_PER1_LO : DPWM_IDX_PER0_LO;
		c = ch ? DPWM_IDX_CTRL1 : DPWM_IDX_CTRL0;
		wr(b, per[3:0]);
		wr(b + 10'h1, per[7:4]);
		wr(b + 10'h2, duty[3:0]);
		wr(b + 10'h3, duty[7:4]);
		wr(ch ? DPWM_IDX_FRAC1 : DPWM_IDX_FRAC0, {2'h0, fr[1:0]});
		wr(c, {pol[0], dv[1:0], 1'b1});
		rd(b + 10'h1, q);
		chk_val(q, {28'h0, per[7:4]});
		rd(b, q);
		chk_val(q, {28'h0, per[3:0]});
		rd(c, q);
		chk_val(q, {28'h0, pol[0], dv[1:0], 1'b1});
		cyc(old_len[ch] + 2 * per * (1 << dv) + 8);
		old_len[ch] = per * (1 << dv);
	endtask : cfg

	task automatic check(input int ch, input int dv, input int pol,
		input int per, input int duty, input int fr);
		int d, l, act, er, h, r;
		d = 1 << dv;
		if (per == 0 || per <= duty || (duty == 0 && fr == 0)) begin
			l = 64;
			act = (per != 0 && per <= duty) ? l : 0;
			er = 0;
		end else begin
			l = 4 * per * d;
			act = (4 * duty + fr) * d;
			er = 4;
		end
		measure(ch, l, h, r);
		chk_cnt(h, pol ? l - act : act);
		chk_cnt(r, er);
		chk_val({31'h0, PIN_OE[ch]}, 32'h1);
	endtask : check

	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		repeat (10) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		cyc(2);
		for (int i = 0; i < 12; i++) begin
			rd(DPWM_IDX_CTRL0 + 10'(i), rdat);
			chk_val(rdat, 32'h0);
		end
		// unmapped word: write dropped, reads as zero
		wr(10'h330, 4'hF);
		rd(10'h330, rdat);
		chk_val(rdat, 32'h0);
		chk_val({31'h0, HRESP}, 32'h0);
		for (int i = 0; i < 2; i++) begin
			@(posedge CORE_CLK);
			GPIO_OUT <= 2'(i + 1);
			GPIO_OE  <= 2'(2 - i);
			cyc(3);
			@(negedge CORE_CLK);
			chk_val({28'h0, PIN_OE, PIN_OUT},
				{28'h0, 2'(2 - i), 2'(i + 1)});
		end
		for (int i = 0; i < 9; i++) begin
			cfg(i % 2, tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4]);
			check(i % 2, tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3],
				tbl[i][4]);
		end
		// deep sleep freezes channel 0 mid-waveform
		@(posedge CORE_CLK);
		DEEP_SLEEP <= 1'b1;
		cyc(6);
		@(negedge CORE_CLK);
		lvl = PIN_OUT[0];
		measure(0, 200, hi, rise);
		chk_cnt(rise, 0);
		chk_cnt(hi, (lvl === 1'b1) ? 200 : 0);
		rd(DPWM_IDX_STAT, rdat);
		chk_val(rdat & 32'h4, 32'h4);
		chk_val(rdat & 32'h1, {31'h0, lvl});
		DEEP_SLEEP <= 1'b0;
		cyc(4);
		check(0, 0, 0, 10, 3, 0);
		// a low nibble alone must not reach the running period
		wr(DPWM_IDX_PER0_LO, 4'h5);
		cyc(30);
		check(0, 0, 0, 10, 3, 0);
		print_verdict();
	end

endmodule : tb_top

// *** hw/dpwm_pkg.sv ***
/*
 * Constants, carriers and helpers shared by the dual pwm block.
 * Assumes a 32-bit ahb-lite bus with one word per 4-bit register.
 */
package dpwm_pkg;

	// ********************************************************
	// sizes
	// ********************************************************
	localparam int DPWM_NCH   = 2;
	localparam int DPWM_VW    = 8;
	localparam int DPWM_NW    = 4;
	localparam int DPWM_NSLOT = 4;

	// ********************************************************
	// register indices (byte address = 4 * index)
	// ********************************************************
	localparam logic [9:0] DPWM_IDX_CTRL0    = 10'h320;
	localparam logic [9:0] DPWM_IDX_CTRL1    = 10'h321;
	localparam logic [9:0] DPWM_IDX_PER0_LO  = 10'h322;
	localparam logic [9:0] DPWM_IDX_PER0_HI  = 10'h323;
	localparam logic [9:0] DPWM_IDX_DUTY0_LO = 10'h324;
	localparam logic [9:0] DPWM_IDX_DUTY0_HI = 10'h325;
	localparam logic [9:0] DPWM_IDX_PER1_LO  = 10'h326;
	localparam logic [9:0] DPWM_IDX_PER1_HI  = 10'h327;
	localparam logic [9:0] DPWM_IDX_DUTY1_LO = 10'h328;
	localparam logic [9:0] DPWM_IDX_DUTY1_HI = 10'h329;
	localparam logic [9:0] DPWM_IDX_FRAC0    = 10'h32A;
	localparam logic [9:0] DPWM_IDX_FRAC1    = 10'h32B;
	localparam logic [9:0] DPWM_IDX_STAT     = 10'h32C;

	// ********************************************************
	// reset values and field positions
	// ********************************************************
	localparam logic [3:0] DPWM_CTRL_RST = 4'h0;
	localparam logic [3:0] DPWM_NIB_RST  = 4'h0;
	localparam logic [1:0] DPWM_FRAC_RST = 2'h0;
	localparam logic [7:0] DPWM_VAL_RST  = 8'h00;
	localparam int DPWM_STAT_LVL0 = 0;
	localparam int DPWM_STAT_LVL1 = 1;
	localparam int DPWM_STAT_STOP = 2;

	// ********************************************************
	// types
	// ********************************************************
	typedef struct packed {
		logic       polarity;
		logic [1:0] div_sel;
		logic       pin_en;
	} dpwm_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] val;
	} dpwm_load_t;

	typedef enum logic [2:0] {
		DPWM_BUS_IDLE = 3'b001,
		DPWM_BUS_WR   = 3'b010,
		DPWM_BUS_RD   = 3'b100
	} dpwm_bus_t;

	// last prescaler count for a divide of 1, 2, 4 or 8
	function automatic logic [2:0] dpwm_div_last(input logic [1:0] sel);
		logic [3:0] span;
		span = 4'h1 << sel;
		return 3'(span - 4'h1);
	endfunction : dpwm_div_last

endpackage : dpwm_pkg

// *** hw/dpwm_prescale.sv ***
/*
 * Count-clock prescaler: one tick every 1, 2, 4 or 8 clocks.
 * Assumes div_sel comes from a register on the same clock.
 */
`timescale 1ns/10ps
module dpwm_prescale (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic [1:0] div_sel,
	input  wire logic       run,
	// tick
	output logic            tick
);
	import dpwm_pkg::*;

	logic [2:0] pre_q;

	// a shrinking divide may leave pre_q above the limit; it wraps
	assign tick = run && (pre_q == dpwm_div_last(div_sel));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 3'h0;
		end else if (tick) begin
			pre_q <= 3'h0;
		end else if (run) begin
			pre_q <= 3'(pre_q + 3'h1);
		end
	end

	a_prescale_span: assert property (
		@(posedge clk) disable iff (!rst_n)
		((tick && div_sel == 2'b11) ##1 (div_sel == 2'b11 && run)[*8])
		|-> tick)
		else $error("divide-by-8 tick spacing wrong");

endmodule : dpwm_prescale

// *** hw/dpwm_sync.sv ***
/*
 * Two-flop level synchroniser.
 * Assumes the input is a slow level from another domain.
 */
`timescale 1ns/10ps
module dpwm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// level
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : dpwm_sync

// *** hw/dpwm_top.sv ***
/*
 * Dual 8-bit pwm generator with ahb-lite register slave.
 * Assumes a single ahb-lite master, word accesses, and a gpio block
 * that supplies the port bits sharing the two pwm pins.
 */
// Behaviour
// - two independent channels, each with 8-bit period and 8-bit duty
// - control bit 0 clear gives gpio on pin, set gives pwm output
// - control bits 2..1 divide count clock by 1, 2, 4 or 8
// - control bit 3 clear drives duty high, set drives duty low
// - output period equals period value times count clock period
// - zero period holds output low, or high when inverted
// - average active time is duty plus fraction over four counts
// - period not above duty holds output high when normal
// - period not above duty holds output low when inverted
// - high nibble write buffers value; it applies from next period
// - runs in light sleep, stops in deep sleep
// - channel 0 shares port bit 0, channel 1 port bit 1
`timescale 1ns/10ps
module dpwm_top (
	// clock and reset
	input  wire logic                          CORE_CLK,
	input  wire logic                          RST_N,
	// ahb-lite slave
	input  wire logic                          HSEL,
	input  wire logic [31:0]                   HADDR,
	input  wire logic [1:0]                    HTRANS,
	input  wire logic                          HWRITE,
	input  wire logic [2:0]                    HSIZE,
	input  wire logic [31:0]                   HWDATA,
	input  wire logic                          HREADY,
	output logic      [31:0]                   HRDATA,
	output logic                               HREADYOUT,
	output logic                               HRESP,
	// sleep
	input  wire logic                          DEEP_SLEEP,
	// shared port pins
	input  wire logic [dpwm_pkg::DPWM_NCH-1:0] GPIO_OUT,
	input  wire logic [dpwm_pkg::DPWM_NCH-1:0] GPIO_OE,
	output logic      [dpwm_pkg::DPWM_NCH-1:0] PIN_OUT,
	output logic      [dpwm_pkg::DPWM_NCH-1:0] PIN_OE
);
	import dpwm_pkg::*;

	// ********************************************************
	// declarations
	// ********************************************************
	dpwm_bus_t  state_q;
	logic [9:0] idx_q;
	logic       ok_q;
	logic       accept;
	logic       wr_cyc;
	logic       rd_cyc;
	logic [3:0] wnib;
	logic [3:0] rd_nib;

	dpwm_ctrl_t ctrl_q   [DPWM_NCH];
	logic [1:0] frac_q   [DPWM_NCH];
	logic [3:0] set_lo_q [DPWM_NSLOT];
	logic [3:0] set_hi_q [DPWM_NSLOT];
	logic [3:0] snap_q   [DPWM_NSLOT];

	logic [DPWM_NCH-1:0]   sel_ctrl;
	logic [DPWM_NCH-1:0]   sel_frac;
	logic [DPWM_NSLOT-1:0] sel_lo;
	logic [DPWM_NSLOT-1:0] sel_hi;
	logic                  sel_stat;

	logic                stop;
	logic [DPWM_NCH-1:0] tick;
	logic [DPWM_NCH-1:0] wrap;
	logic [DPWM_NCH-1:0] lvl;
	logic [DPWM_NCH-1:0] pwm_q;
	dpwm_load_t          per_ld  [DPWM_NCH];
	dpwm_load_t          duty_ld [DPWM_NCH];

	logic [7:0] per_q     [DPWM_NCH];
	logic [7:0] duty_q    [DPWM_NCH];
	logic [7:0] per_pend  [DPWM_NCH];
	logic [7:0] duty_pend [DPWM_NCH];
	logic       per_pv    [DPWM_NCH];
	logic       duty_pv   [DPWM_NCH];
	logic [7:0] cnt_q     [DPWM_NCH];
	logic [1:0] phase_q   [DPWM_NCH];
	logic [1:0] fract_q   [DPWM_NCH];

	// ********************************************************
	// ahb-lite slave
	// ********************************************************
	// writes finish with no wait; reads take one wait state so that a
	// write in the preceding data phase is always seen
	assign accept = HSEL && HTRANS[1] && HREADY;
	assign wr_cyc = (state_q == DPWM_BUS_WR);
	assign rd_cyc = (state_q == DPWM_BUS_RD);
	assign wnib   = HWDATA[3:0];

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q   <= DPWM_BUS_IDLE;
			idx_q     <= 10'h000;
			ok_q      <= 1'b0;
			HREADYOUT <= 1'b1;
			HRDATA    <= 32'h0000_0000;
		end else begin
			case (state_q)
				DPWM_BUS_IDLE, DPWM_BUS_WR: begin
					if (accept) begin
						idx_q     <= HADDR[11:2];
						ok_q      <= (HADDR[31:12] == 20'h00000) &&
						             (HADDR[1:0] == 2'h0);
						state_q   <= HWRITE ? DPWM_BUS_WR : DPWM_BUS_RD;
						HREADYOUT <= HWRITE;
					end else begin
						state_q <= DPWM_BUS_IDLE;
					end
				end
				DPWM_BUS_RD: begin
					HRDATA    <= {28'h000_0000, rd_nib};
					HREADYOUT <= 1'b1;
					state_q   <= DPWM_BUS_IDLE;
				end
				default: begin
					state_q   <= DPWM_BUS_IDLE;
					HREADYOUT <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRESP <= 1'b0;
		end else begin
			HRESP <= 1'b0;
		end
	end

	// ********************************************************
	// address decode
	// ********************************************************
	always_comb begin
		sel_ctrl = '0;
		sel_frac = '0;
		sel_lo   = '0;
		sel_hi   = '0;
		sel_stat = 1'b0;
		if (!ok_q) begin
			sel_stat = 1'b0;
		end else if (idx_q == DPWM_IDX_CTRL0) begin
			sel_ctrl[0] = 1'b1;
		end else if (idx_q == DPWM_IDX_CTRL1) begin
			sel_ctrl[1] = 1'b1;
		end else if (idx_q == DPWM_IDX_PER0_LO) begin
			sel_lo[0] = 1'b1;
		end else if (idx_q == DPWM_IDX_PER0_HI) begin
			sel_hi[0] = 1'b1;
		end else if (idx_q == DPWM_IDX_DUTY0_LO) begin
			sel_lo[1] = 1'b1;
		end else if (idx_q == DPWM_IDX_DUTY0_HI) begin
			sel_hi[1] = 1'b1;
		end else if (idx_q == DPWM_IDX_PER1_LO) begin
			sel_lo[2] = 1'b1;
		end else if (idx_q == DPWM_IDX_PER1_HI) begin
			sel_hi[2] = 1'b1;
		end else if (idx_q == DPWM_IDX_DUTY1_LO) begin
			sel_lo[3] = 1'b1;
		end else if (idx_q == DPWM_IDX_DUTY1_HI) begin
			sel_hi[3] = 1'b1;
		end else if (idx_q == DPWM_IDX_FRAC0) begin
			sel_frac[0] = 1'b1;
		end else if (idx_q == DPWM_IDX_FRAC1) begin
			sel_frac[1] = 1'b1;
		end else if (idx_q == DPWM_IDX_STAT) begin
			sel_stat = 1'b1;
		end
	end

	// ********************************************************
	// read mux
	// ********************************************************
	// low nibble reads return the frozen copy
	always_comb begin
		rd_nib = 4'h0;
		for (int s = 0; s < DPWM_NSLOT; s++) begin
			if (sel_hi[s]) begin
				rd_nib = set_hi_q[s];
			end else if (sel_lo[s]) begin
				rd_nib = snap_q[s];
			end
		end
		for (int c = 0; c < DPWM_NCH; c++) begin
			if (sel_ctrl[c]) begin
				rd_nib = ctrl_q[c];
			end else if (sel_frac[c]) begin
				rd_nib = {2'h0, frac_q[c]};
			end
		end
		if (sel_stat) begin
			rd_nib[DPWM_STAT_LVL0] = pwm_q[0];
			rd_nib[DPWM_STAT_LVL1] = pwm_q[1];
			rd_nib[DPWM_STAT_STOP] = stop;
		end
	end

	// ********************************************************
	// setting registers
	// ********************************************************
	// slots: 0 period0, 1 duty0, 2 period1, 3 duty1
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int s = 0; s < DPWM_NSLOT; s++) begin
				set_lo_q[s] <= DPWM_NIB_RST;
				set_hi_q[s] <= DPWM_NIB_RST;
			end
		end else if (wr_cyc) begin
			for (int s = 0; s < DPWM_NSLOT; s++) begin
				if (sel_lo[s]) begin
					set_lo_q[s] <= wnib;
				end
				if (sel_hi[s]) begin
					set_hi_q[s] <= wnib;
				end
			end
		end
	end

	// snapshot of the low nibble, taken on a high nibble read
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int s = 0; s < DPWM_NSLOT; s++) begin
				snap_q[s] <= DPWM_NIB_RST;
			end
		end else begin
			for (int s = 0; s < DPWM_NSLOT; s++) begin
				if (rd_cyc && sel_hi[s]) begin
					snap_q[s] <= set_lo_q[s];
				end else if (wr_cyc && sel_lo[s]) begin
					snap_q[s] <= wnib;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int c = 0; c < DPWM_NCH; c++) begin
				ctrl_q[c] <= dpwm_ctrl_t'(DPWM_CTRL_RST);
				frac_q[c] <= DPWM_FRAC_RST;
			end
		end else if (wr_cyc) begin
			for (int c = 0; c < DPWM_NCH; c++) begin
				if (sel_ctrl[c]) begin
					ctrl_q[c] <= dpwm_ctrl_t'(wnib);
				end
				if (sel_frac[c]) begin
					frac_q[c] <= wnib[1:0];
				end
			end
		end
	end

	// ********************************************************
	// deep sleep
	// ********************************************************
	dpwm_sync #(
		.W (1)
	) u_sleep_sync (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.d     (DEEP_SLEEP),
		.q     (stop)
	);

	// ********************************************************
	// channels
	// ********************************************************
	for (genvar c = 0; c < DPWM_NCH; c++) begin : g_ch
		logic [8:0] duty_eff;

		// full value goes out only on the high nibble write
		assign per_ld[c].wr   = wr_cyc && sel_hi[2*c];
		assign per_ld[c].val  = {wnib, set_lo_q[2*c]};
		assign duty_ld[c].wr  = wr_cyc && sel_hi[2*c+1];
		assign duty_ld[c].val = {wnib, set_lo_q[2*c+1]};

		// light sleep changes nothing; deep sleep freezes the tick
		dpwm_prescale u_pre (
			.clk     (CORE_CLK),
			.rst_n   (RST_N),
			.div_sel (ctrl_q[c].div_sel),
			.run     (!stop),
			.tick    (tick[c])
		);

		// last count of the period, or every tick when period is zero
		assign wrap[c] = tick[c] &&
			(({1'b0, cnt_q[c]} + 9'h001) >= {1'b0, per_q[c]});

		// reload buffer; a write in a wrap cycle waits for the next
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				per_pend[c] <= DPWM_VAL_RST;
				per_pv[c]   <= 1'b0;
			end else if (per_ld[c].wr) begin
				per_pend[c] <= per_ld[c].val;
				per_pv[c]   <= 1'b1;
			end else if (wrap[c]) begin
				per_pv[c] <= 1'b0;
			end
		end

		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				duty_pend[c] <= DPWM_VAL_RST;
				duty_pv[c]   <= 1'b0;
			end else if (duty_ld[c].wr) begin
				duty_pend[c] <= duty_ld[c].val;
				duty_pv[c]   <= 1'b1;
			end else if (wrap[c]) begin
				duty_pv[c] <= 1'b0;
			end
		end

		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				per_q[c]  <= DPWM_VAL_RST;
				duty_q[c] <= DPWM_VAL_RST;
			end else if (wrap[c]) begin
				if (per_pv[c]) begin
					per_q[c] <= per_pend[c];
				end
				if (duty_pv[c]) begin
					duty_q[c] <= duty_pend[c];
				end
			end
		end

		// period counter
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				cnt_q[c] <= DPWM_VAL_RST;
			end else if (wrap[c]) begin
				cnt_q[c] <= DPWM_VAL_RST;
			end else if (tick[c]) begin
				cnt_q[c] <= 8'(cnt_q[c] + 8'h01);
			end
		end

		// fraction spreads up to three extra counts over a four-period cycle
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				phase_q[c] <= 2'h0;
				fract_q[c] <= DPWM_FRAC_RST;
			end else if (wrap[c]) begin
				phase_q[c] <= 2'(phase_q[c] + 2'h1);
				fract_q[c] <= frac_q[c];
			end
		end

		assign duty_eff = {1'b0, duty_q[c]} +
			{8'h00, (phase_q[c] < fract_q[c])};

		always_comb begin
			if (per_q[c] == DPWM_VAL_RST) begin
				lvl[c] = 1'b0;
			end else if (per_q[c] <= duty_q[c]) begin
				lvl[c] = 1'b1;
			end else begin
				lvl[c] = ({1'b0, cnt_q[c]} < duty_eff);
			end
		end

		// polarity is live, not buffered with the period
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				pwm_q[c] <= 1'b0;
			end else if (!stop) begin
				pwm_q[c] <= lvl[c] ^ ctrl_q[c].polarity;
			end
		end

		// pin sharing with the port bit of the same number
		always_ff @(posedge CORE_CLK or negedge RST_N) begin
			if (!RST_N) begin
				PIN_OUT[c] <= 1'b0;
				PIN_OE[c]  <= 1'b0;
			end else if (ctrl_q[c].pin_en) begin
				PIN_OUT[c] <= pwm_q[c];
				PIN_OE[c]  <= 1'b1;
			end else begin
				PIN_OUT[c] <= GPIO_OUT[c];
				PIN_OE[c]  <= GPIO_OE[c];
			end
		end

		a_zero_period: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			(!stop && per_q[c] == 8'h00)
			|=> (pwm_q[c] == $past(ctrl_q[c].polarity)))
			else $error("zero period level wrong");

		a_full_normal: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			(!stop && per_q[c] != 8'h00 && per_q[c] <= duty_q[c] &&
			 !ctrl_q[c].polarity) |=> pwm_q[c])
			else $error("full duty not high");

		a_full_invert: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			(!stop && per_q[c] != 8'h00 && per_q[c] <= duty_q[c] &&
			 ctrl_q[c].polarity) |=> !pwm_q[c])
			else $error("inverted full duty not low");

		a_stop_hold: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			stop |=> ($stable(pwm_q[c]) && $stable(cnt_q[c])))
			else $error("channel moved in deep sleep");

		a_wrap_zero: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			wrap[c] |=> (cnt_q[c] == 8'h00))
			else $error("count did not wrap to zero");

		a_count_bound: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			(per_q[c] != 8'h00) |-> (cnt_q[c] < per_q[c]))
			else $error("count passed period");

		a_reload_apply: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			(wrap[c] && per_pv[c] && duty_pv[c])
			|=> (per_q[c] == $past(per_pend[c]) &&
			     duty_q[c] == $past(duty_pend[c])))
			else $error("buffered value not applied at wrap");

		a_pin_gpio: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			!ctrl_q[c].pin_en |=> (PIN_OUT[c] == $past(GPIO_OUT[c])))
			else $error("pin not following port bit");

		a_pin_pwm: assert property (
			@(posedge CORE_CLK) disable iff (!RST_N)
			ctrl_q[c].pin_en |=> (PIN_OUT[c] == $past(pwm_q[c]) && PIN_OE[c]))
			else $error("pin not carrying pwm");
	end

endmodule : dpwm_top
